/* File: rtl/scr_pkg.sv */
// constants and types of the serial command router and config store
package scr_pkg;
  localparam int CLK_MHZ = 100;
  localparam int CHAR_TIME_US = 1042; // one character at 9600 baud
  localparam int CHAR_CYCLES = CHAR_TIME_US * CLK_MHZ;
  localparam int RX_DEPTH = 256;
  localparam int RTX_DEPTH = 256;
  localparam int RTX_MSGS = 32;
  localparam int CMD_DEPTH = 128;
  localparam int TX_DEPTH = 256;
  localparam int RRX_DEPTH = 256;
  localparam int RSP_DEPTH = 256;
  localparam int SKID_DEPTH = 2;
  localparam int DEV_WORDS = 64;
  localparam logic [7:0] USR_RW_FIRST = 8'h4B; // index 75
  localparam logic [7:0] USR_RW_LAST = 8'h60; // index 96
  localparam logic [6:0] COPY_LAST = 7'h60;
  localparam logic [5:0] DEV_IDX_TIMEOUT = 6'h0C;
  localparam logic [7:0] CMD_PORT = 8'hA0; // port 160
  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_Q = 8'h51;
  localparam logic [7:0] FACTORY_DEV = 8'h00;
  localparam logic [7:0] FACTORY_USR = 8'h00;
  localparam logic [1:0] ESC_RUN_LAST = 2'h2;
  localparam logic [31:0] GAP_RESET = 32'hFFFFFFFF;
  typedef struct packed {
    logic first;
    logic [7:0] data;
  } scr_byte_t;
  typedef enum logic [3:0] {
    OP_DEV_RD, OP_DEV_WR, OP_USR_RD, OP_USR_WR, OP_SAVE_DEV,
    OP_SAVE_USR, OP_RST_DEV, OP_RST_USR, OP_FACTORY
  } scr_op_t;
  typedef struct packed {
    scr_op_t op;
    logic [7:0] idx;
    logic [7:0] wdata;
  } scr_cfg_req_t;
  typedef enum logic [1:0] {CS_BOOT, CS_IDLE, CS_COPY} scr_cfg_state_t;
endpackage

/* File: rtl/scr_router.sv */
// serial command router with byte buffers and configuration store
//
// Behaviour
// R1: three separate pluses: command mode, two forwarded
// R2: three pluses in one frame: none forwarded
// R3: in command mode serial bytes are commands
// R4: downlink on port 160 is a command
// R5: sender ends commands with CR or LF
// R6: serial bytes steered by mode to buffer
// R7: radio data and responses go to serial
// R8: serial receive buffer 256 bytes, overflow dropped
// R9: radio transmit: 32 messages, 256 bytes total
// R10: one command up to 128 bytes; busy drops
// R11: serial tx, radio rx, response: 256 each
// R12: device config readable and writable
// R13: user parameters 75 to 96 read/write
// R14: identifier entries 0 to 74 read only
// R15: boot copies stored config into working copy
// R16: block runs from the working copy
// R17: device config write is RAM; save stores
// R18: user param write is RAM; save stores
// R19: factory restore rewrites store, keeps identifiers
// R20: restore reloads working copy from store
// R21: exit command plus terminator leaves command mode
// R22: one frame while gaps stay under timeout
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module scr_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys, // system clock
  input wire logic srst, // sync reset
  input wire logic inValid, // write offered
  output logic inReady, // room left
  input wire logic [W-1:0] inData, // write data
  output logic outValid, // entry present
  input wire logic outReady, // reader takes
  output logic [W-1:0] outData, // head entry
  output logic [$clog2(DEPTH+1)-1:0] count // entries held
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;
  assign inReady = count != DEPTH[$clog2(DEPTH+1)-1:0];
  assign outValid = count != '0;
  assign outData = mem[rdPtr];
  // storage
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end
  // pointers and fill level
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= push ? wrPtr + 1'b1 : wrPtr;
      rdPtr <= pop ? rdPtr + 1'b1 : rdPtr;
      count <= count + {{($clog2(DEPTH+1)-1){1'b0}}, push} - {{($clog2(DEPTH+1)-1){1'b0}}, pop};
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module scr_router import scr_pkg::*; #(
  parameter int CHAR_CYC = CHAR_CYCLES
) (
  input wire logic clk_sys, // system clock
  input wire logic srst, // sync reset
  input wire logic rxValid, // byte from uart receiver
  input wire logic [7:0] rxData, // received byte
  output logic radioTxValid, // radio payload byte
  output scr_byte_t radioTxByte, // byte with message start
  input wire logic radioTxReady, // radio takes byte
  input wire logic dlValid, // downlink byte
  input wire logic [7:0] dlPort, // downlink port
  input wire logic [7:0] dlData, // downlink byte value
  output logic dlReady, // downlink byte taken
  input wire logic radioRxValid, // radio received byte
  input wire logic [7:0] radioRxData, // its value
  output logic radioRxReady, // room for it
  input wire logic rspValid, // command response byte
  input wire logic [7:0] rspData, // its value
  output logic rspReady, // room for it
  output logic serTxValid, // byte for uart sender
  output logic [7:0] serTxData, // its value
  input wire logic serTxReady, // uart sender takes
  output logic cmdMode, // command mode active
  output logic cmdValid, // command waits for execution
  output logic [7:0] cmdLen, // bytes in command
  input wire logic [6:0] cmdRdAddr, // command byte address
  output logic [7:0] cmdRdData, // command byte, one cycle later
  input wire logic cmdDone, // command executed
  input wire logic cfgReqValid, // config request
  input wire scr_cfg_req_t cfgReq, // operation, index, data
  output logic cfgReady, // store idle
  output logic cfgRdValid, // read data pulse
  output logic [7:0] cfgRdData, // read data
  output logic cfgDone, // write or copy finished pulse
  output logic booted // boot load complete
);
  logic [7:0] devRam [DEV_WORDS];
  logic [7:0] devNv [DEV_WORDS];
  logic [7:0] usrRam [97];
  logic [7:0] usrNv [97];
  logic [7:0] cmdMem [CMD_DEPTH];
  logic [31:0] gapCnt;
  logic [1:0] plusRun;
  logic [1:0] heldCnt;
  logic heldFirst;
  logic dropMsg;
  logic [5:0] msgCnt;
  scr_cfg_state_t cfgState;
  logic [6:0] copyIdx;
  scr_op_t copyOp;

  // nonvolatile store starts blank at factory values
  initial begin
    for (int i = 0; i < DEV_WORDS; i++) begin
      devNv[i] = FACTORY_DEV;
    end
    for (int i = 0; i < 97; i++) begin
      usrNv[i] = FACTORY_USR;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // frame gap timing from the working copy
  // R16: timing from working copy
  wire [7:0] tmoRaw = devRam[DEV_IDX_TIMEOUT];
  wire [7:0] tmoChars = (tmoRaw == 8'h00) ? 8'h01 : tmoRaw;
  wire [31:0] gapLimit = booted ? 32'(int'(tmoChars) * CHAR_CYC) : 32'(CHAR_CYC);
  // R22: gap splits frames
  wire newFrame = gapCnt >= gapLimit;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gapCnt <= GAP_RESET;
    end else begin
      gapCnt <= rxValid ? 32'h0 : (gapCnt == GAP_RESET ? gapCnt : gapCnt + 32'h1);
    end
  end

  // R8: no back-pressure, full drops
  scr_byte_t rxHead;
  logic rxHeadValid;
  logic rxPop;
  logic [8:0] rxCnt;
  scr_fifo #(.W($bits(scr_byte_t)), .DEPTH(RX_DEPTH)) uRx (
    .clk_sys(clk_sys), .srst(srst), .inValid(rxValid), .inReady(),
    .inData({newFrame, rxData}), .outValid(rxHeadValid), .outReady(rxPop),
    .outData(rxHead), .count(rxCnt));

  //////////////////////////////////////////////////////////////////////////////
  // escape detection and steering of serial bytes
  wire isPlus = rxHead.data == CH_PLUS;
  wire normMode = booted && !cmdMode;
  wire normHead = rxHeadValid && normMode;
  // held pluses leave at a new frame, a non-plus byte or a frame timeout
  wire frameOver = !rxHeadValid && newFrame;
  wire flushNow = normMode && heldCnt != 2'h0 &&
    (frameOver || (rxHeadValid && (!isPlus || rxHead.first)));
  wire escDone = normHead && !flushNow && isPlus && plusRun == ESC_RUN_LAST;
  // R2: each plus but the third of a run waits until its frame shows its kind
  wire holdPlus = normHead && !flushNow && !escDone && isPlus;
  wire fwdByte = normHead && !flushNow && !escDone && !holdPlus;
  // R15: no serial traffic until boot load ends
  assign rxPop = rxHeadValid && booted && !flushNow;
  wire rtxWr = flushNow || fwdByte;
  wire scr_byte_t rtxWrByte = flushNow ? {heldFirst, CH_PLUS} : rxHead;
  logic rtxInReady;
  // R9: message and byte limits, rest of message dropped
  wire rtxAccept = rtxWr && rtxInReady &&
    (rtxWrByte.first ? msgCnt < 6'(RTX_MSGS) : !dropMsg);
  wire rtxPopFirst = radioTxValid && radioTxReady && radioTxByte.first;
  // R1: separate pluses forwarded until the third
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      plusRun <= 2'h0;
      heldCnt <= 2'h0;
      heldFirst <= 1'b0;
    end else if (escDone) begin
      plusRun <= 2'h0;
      heldCnt <= 2'h0;
      heldFirst <= 1'b0;
    end else if (flushNow) begin
      heldCnt <= heldCnt - 2'h1;
      heldFirst <= 1'b0;
    end else if (normHead) begin
      plusRun <= isPlus ? plusRun + 2'h1 : 2'h0;
      heldCnt <= holdPlus ? heldCnt + 2'h1 : heldCnt;
      heldFirst <= (holdPlus && heldCnt == 2'h0) ? rxHead.first : heldFirst;
    end
  end
  // message bookkeeping of the radio queue
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dropMsg <= 1'b0;
      msgCnt <= 6'h0;
    end else begin
      dropMsg <= rtxWr ? !rtxAccept : dropMsg;
      msgCnt <= msgCnt + {5'h0, rtxAccept && rtxWrByte.first} - {5'h0, rtxPopFirst};
    end
  end
  // R6: normal mode bytes to radio queue
  scr_fifo #(.W($bits(scr_byte_t)), .DEPTH(RTX_DEPTH)) uRtx (
    .clk_sys(clk_sys), .srst(srst), .inValid(rtxAccept), .inReady(rtxInReady),
    .inData(rtxWrByte), .outValid(radioTxValid), .outReady(radioTxReady),
    .outData(radioTxByte), .count());

  //////////////////////////////////////////////////////////////////////////////
  // command receive buffer, serial first, downlink when serial idle
  // R3: command mode bytes are command text
  wire cmdHead = rxHeadValid && booted && cmdMode;
  // R4: downlink port selects commands
  wire dlTake = dlValid && !cmdHead && dlPort == CMD_PORT;
  assign dlReady = !cmdHead;
  wire cbValid = cmdHead || dlTake;
  wire [7:0] cb = cmdHead ? rxHead.data : dlData;
  wire cbTerm = cb == CH_CR || cb == CH_LF;
  // R10: busy buffer drops new bytes
  wire cbTake = cbValid && !cmdValid;
  wire cbStore = cbTake && !cbTerm && cmdLen < 8'(CMD_DEPTH);
  wire isExit = cmdLen == 8'h03 && cmdMem[0] == CH_A && cmdMem[1] == CH_T && cmdMem[2] == CH_Q;
  // R21: exit text closes command mode
  wire exitHit = cbTake && cbTerm && isExit;
  wire cmdEnd = cbTake && cbTerm && cmdLen != 8'h00 && !isExit;
  always_ff @(posedge clk_sys) begin
    if (cbStore) begin
      cmdMem[cmdLen[6:0]] <= cb;
    end
    cmdRdData <= cmdMem[cmdRdAddr];
  end
  // mode and command state; entry wins over exit
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmdMode <= 1'b0;
      cmdValid <= 1'b0;
      cmdLen <= 8'h00;
    end else begin
      cmdMode <= escDone || (cmdMode && !exitHit);
      cmdValid <= cmdEnd || (cmdValid && !cmdDone);
      if (exitHit || (cmdValid && cmdDone)) begin
        cmdLen <= 8'h00;
      end else if (cbStore) begin
        cmdLen <= cmdLen + 8'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // R11: 256 byte radio rx, response and serial tx queues
  logic rrValid;
  logic [7:0] rrData;
  logic rsValid;
  logic [7:0] rsData;
  logic txInReady;
  logic skInReady;
  logic txValid;
  logic [7:0] txData;
  scr_fifo #(.W(8), .DEPTH(RRX_DEPTH)) uRrx (
    .clk_sys(clk_sys), .srst(srst), .inValid(radioRxValid), .inReady(radioRxReady),
    .inData(radioRxData), .outValid(rrValid), .outReady(txInReady && !rsValid),
    .outData(rrData), .count());
  scr_fifo #(.W(8), .DEPTH(RSP_DEPTH)) uRsp (
    .clk_sys(clk_sys), .srst(srst), .inValid(rspValid), .inReady(rspReady),
    .inData(rspData), .outValid(rsValid), .outReady(txInReady),
    .outData(rsData), .count());
  // R7: responses first, then radio data
  scr_fifo #(.W(8), .DEPTH(TX_DEPTH)) uTx (
    .clk_sys(clk_sys), .srst(srst), .inValid(rsValid || rrValid), .inReady(txInReady),
    .inData(rsValid ? rsData : rrData), .outValid(txValid), .outReady(skInReady),
    .outData(txData), .count());
  scr_fifo #(.W(8), .DEPTH(SKID_DEPTH)) uSkid (
    .clk_sys(clk_sys), .srst(srst), .inValid(txValid), .inReady(skInReady),
    .inData(txData), .outValid(serTxValid), .outReady(serTxReady),
    .outData(serTxData), .count());

  //////////////////////////////////////////////////////////////////////////////
  // configuration store: boot load, access, save, restore, factory
  wire copying = cfgState != CS_IDLE;
  wire boot = cfgState == CS_BOOT;
  wire inDev = copyIdx < 7'(DEV_WORDS);
  wire [5:0] ci6 = copyIdx[5:0];
  wire reqTake = cfgReqValid && cfgState == CS_IDLE;
  wire reqDevOk = cfgReq.idx < 8'(DEV_WORDS);
  wire reqUsrOk = cfgReq.idx <= USR_RW_LAST;
  wire reqCopy = cfgReq.op inside {OP_SAVE_DEV, OP_SAVE_USR, OP_RST_DEV, OP_RST_USR,
    OP_FACTORY};
  // R12: device config access; R17: RAM only
  wire devWr = reqTake && cfgReq.op == OP_DEV_WR && reqDevOk;
  // R13: R14: only parameter indices take writes; R18: RAM only
  wire usrWr = reqTake && cfgReq.op == OP_USR_WR && cfgReq.idx >= USR_RW_FIRST && reqUsrOk;
  // R15: R20: store to working copy
  wire devLoad = copying && inDev && (boot || copyOp == OP_RST_DEV);
  wire usrLoad = copying && (boot || copyOp == OP_RST_USR);
  // R17: R18: R19: only save and factory touch the store
  wire devSave = cfgState == CS_COPY && inDev && copyOp inside {OP_SAVE_DEV, OP_FACTORY};
  wire usrSave = cfgState == CS_COPY && (copyOp == OP_SAVE_USR ||
    (copyOp == OP_FACTORY && {1'b0, copyIdx} >= USR_RW_FIRST));
  wire [7:0] rdSel = cfgReq.op == OP_DEV_RD ? (reqDevOk ? devRam[cfgReq.idx[5:0]] : 8'h00)
    : (reqUsrOk ? usrRam[cfgReq.idx[6:0]] : 8'h00);
  assign cfgReady = cfgState == CS_IDLE;
  assign booted = !boot;
  // array writes
  always_ff @(posedge clk_sys) begin
    if (devLoad) begin
      devRam[ci6] <= devNv[ci6];
    end else if (devWr) begin
      devRam[cfgReq.idx[5:0]] <= cfgReq.wdata;
    end
    if (usrLoad) begin
      usrRam[copyIdx] <= usrNv[copyIdx];
    end else if (usrWr) begin
      usrRam[cfgReq.idx[6:0]] <= cfgReq.wdata;
    end
    if (devSave) begin
      devNv[ci6] <= copyOp == OP_FACTORY ? FACTORY_DEV : devRam[ci6];
    end
    if (usrSave) begin
      usrNv[copyIdx] <= copyOp == OP_FACTORY ? FACTORY_USR : usrRam[copyIdx];
    end
  end
  // sequencing of the store
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfgState <= CS_BOOT;
      copyIdx <= 7'h00;
      copyOp <= OP_DEV_RD;
      cfgRdValid <= 1'b0;
      cfgRdData <= 8'h00;
      cfgDone <= 1'b0;
    end else begin
      cfgRdValid <= reqTake && cfgReq.op inside {OP_DEV_RD, OP_USR_RD};
      cfgRdData <= reqTake ? rdSel : cfgRdData;
      cfgDone <= (reqTake && cfgReq.op inside {OP_DEV_WR, OP_USR_WR}) ||
        (cfgState == CS_COPY && copyIdx == COPY_LAST);
      unique case (cfgState)
        CS_BOOT, CS_COPY: begin
          copyIdx <= copyIdx == COPY_LAST ? 7'h00 : copyIdx + 7'h01;
          cfgState <= copyIdx == COPY_LAST ? CS_IDLE : cfgState;
        end
        CS_IDLE: begin
          if (reqTake && reqCopy) begin
            copyOp <= cfgReq.op;
            cfgState <= CS_COPY;
          end
        end
        default: cfgState <= CS_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_esc_sep; escDone && rxHead.first |=> cmdMode && !rtxWr; endproperty
  a_esc_sep: assert property (p_esc_sep) else $error("separate escape missed"); // R1
  property p_esc_frame; holdPlus |-> !rtxWr ##1 (heldCnt != 2'h0 || cmdMode); endproperty
  a_esc_frame: assert property (p_esc_frame) else $error("held plus forwarded"); // R2
  property p_cmd_steer; cmdHead |-> !rtxWr && !fwdByte; endproperty
  a_cmd_steer: assert property (p_cmd_steer) else $error("command byte sent to radio"); // R3
  property p_dl_port; dlValid && dlPort != CMD_PORT |-> !dlTake; endproperty
  a_dl_port: assert property (p_dl_port) else $error("wrong port taken"); // R4
  property p_fwd; fwdByte |-> rtxWr && rtxWrByte == rxHead; endproperty
  a_fwd: assert property (p_fwd) else $error("normal byte not steered"); // R6
  property p_rx_drop; rxValid && rxCnt == 9'h100 && rxPop |=> rxCnt == 9'h0FF; endproperty
  a_rx_drop: assert property (p_rx_drop) else $error("full receive queue grew"); // R8
  property p_msgs; rtxWr && rtxWrByte.first && msgCnt == 6'h20 |-> !rtxAccept; endproperty
  a_msgs: assert property (p_msgs) else $error("message limit passed"); // R9
  property p_busy; cmdValid && !cmdDone |=> cmdLen == $past(cmdLen) && cmdValid; endproperty
  a_busy: assert property (p_busy) else $error("busy command changed"); // R10
  property p_id_ro; cfgReady && cfgReqValid && cfgReq.op == OP_USR_WR &&
    cfgReq.idx < USR_RW_FIRST |=>
    usrRam[$past(cfgReq.idx[6:0])] == $past(usrRam[cfgReq.idx[6:0]]); endproperty
  a_id_ro: assert property (p_id_ro) else $error("identifier written"); // R14
  property p_boot; !booted |-> !rxPop && !cfgReady; endproperty
  a_boot: assert property (p_boot) else $error("traffic before boot load"); // R15
  property p_exit; $fell(cmdMode) |-> $past(exitHit); endproperty
  a_exit: assert property (p_exit) else $error("left mode without exit"); // R21
  c_esc_sep: cover property (escDone && rxHead.first);
  c_esc_frame: cover property (escDone && !rxHead.first);
  c_cmd: cover property ($rose(cmdValid));
  c_copy: cover property (cfgDone && copyOp == OP_FACTORY);
endmodule

/* File: bench/scr_host_model.sv */
// host-side uart byte model: sends bytes to the router and takes what it returns
`timescale 1ns/1ps

module scr_host_model import scr_pkg::*; (
  input wire logic clk_sys, // system clock
  output logic rxValid, // byte pulse toward the router
  output logic [7:0] rxData, // byte value
  input wire logic serTxValid, // router offers a byte
  input wire logic [7:0] serTxData, // offered byte
  output logic serTxReady // host accepts bytes
);
  logic [7:0] txQ[$];

  initial begin
    rxValid = 1'b0;
    rxData = 8'h00;
    serTxReady = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // collect every byte handed over by the router
  always @(posedge clk_sys) begin
    if (serTxValid && serTxReady) begin
      txQ.push_back(serTxData);
    end
  end

  // idle gap, one byte pulse, then the line shows the inverse so stale data never matches
  task automatic sendByte(input logic [7:0] b, input int gap);
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    rxValid <= 1'b1;
    rxData <= b;
    @(posedge clk_sys);
    rxValid <= 1'b0;
    rxData <= ~b;
  endtask

  task automatic sendCmd(input string s);
    foreach (s[i]) sendByte(s[i], 0);
    sendByte(CH_CR, 0);
  endtask

  // host stalls or releases the router's transmit side
  task automatic setReady(input logic r);
    @(posedge clk_sys);
    serTxReady <= r;
  endtask
endmodule

/* File: bench/tb_serial_command_router_config_store.sv */
// self-checking bench of the serial command router and config store
`timescale 1ns/1ps
`define CHK(act, exp) begin testsRun++; if ((act) !== (exp)) begin errCount++; \
  $display("[ERR] %0t got %0h exp %0h", $time, act, exp); end end
`define WAIT(c, lim) begin int k; k = 0; while (!(c) && k < lim) begin \
  @(posedge clk_sys); k++; end `CHK(c, 1'b1) end

module tb_serial_command_router_config_store import scr_pkg::*;;
  localparam int CC = 20; // short character time
  localparam string EXIT_TXT = {"AT", "Q"}; // exit command text
  logic clk_sys = 1'b0, srst = 1'b1, rxValid, radioTxValid, radioTxReady = 1'b1;
  logic dlValid = 1'b0, dlReady, radioRxValid = 1'b0, radioRxReady, rspValid = 1'b0;
  logic rspReady, serTxValid, serTxReady, cmdMode, cmdValid, cmdDone = 1'b0;
  logic cfgReqValid = 1'b0, cfgReady, cfgRdValid, cfgDone, booted;
  logic [7:0] rxData, dlPort = 8'h00, dlData = 8'h00, radioRxData = 8'h00, rspData = 8'h00;
  logic [7:0] serTxData, cmdLen, cmdRdData, cfgRdData, rd, idv;
  logic [6:0] cmdRdAddr = 7'h00;
  scr_byte_t radioTxByte;
  scr_cfg_req_t cfgReq = '0;
  scr_byte_t radioQ[$];
  int errCount = 0, testsRun = 0;

  always #5 clk_sys = ~clk_sys;

  // collect bytes leaving toward the radio
  always @(posedge clk_sys) begin
    if (radioTxValid && radioTxReady) radioQ.push_back(radioTxByte);
  end

  scr_router #(.CHAR_CYC(CC)) dut_u (.clk_sys(clk_sys), .srst(srst), .rxValid(rxValid),
    .rxData(rxData), .radioTxValid(radioTxValid), .radioTxByte(radioTxByte),
    .radioTxReady(radioTxReady), .dlValid(dlValid), .dlPort(dlPort), .dlData(dlData),
    .dlReady(dlReady), .radioRxValid(radioRxValid), .radioRxData(radioRxData),
    .radioRxReady(radioRxReady), .rspValid(rspValid), .rspData(rspData), .rspReady(rspReady),
    .serTxValid(serTxValid), .serTxData(serTxData), .serTxReady(serTxReady),
    .cmdMode(cmdMode), .cmdValid(cmdValid), .cmdLen(cmdLen), .cmdRdAddr(cmdRdAddr),
    .cmdRdData(cmdRdData), .cmdDone(cmdDone), .cfgReqValid(cfgReqValid), .cfgReq(cfgReq),
    .cfgReady(cfgReady), .cfgRdValid(cfgRdValid), .cfgRdData(cfgRdData), .cfgDone(cfgDone),
    .booted(booted));

  scr_host_model host_u (.clk_sys(clk_sys), .rxValid(rxValid), .rxData(rxData),
    .serTxValid(serTxValid), .serTxData(serTxData), .serTxReady(serTxReady));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic endOfTest;
    if (errCount == 0 && testsRun > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic doReset;
    @(posedge clk_sys) srst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    `CHK({cmdMode, cmdValid, booted, cfgReady, serTxValid}, 5'h00)
    srst <= 1'b0;
    `WAIT(booted, 200)
  endtask

  // one handshake on response (0), radio receive (1) or downlink (2)
  task automatic push(input int sel, input logic [7:0] port, input logic [7:0] b);
    int n;
    n = 0;
    @(posedge clk_sys);
    if (sel == 0) begin
      rspValid <= 1'b1;
      rspData <= b;
    end else if (sel == 1) begin
      radioRxValid <= 1'b1;
      radioRxData <= b;
    end else begin
      dlValid <= 1'b1;
      dlPort <= port;
      dlData <= b;
    end
    do begin @(posedge clk_sys); n++; end
    while (!(sel == 0 ? rspReady : sel == 1 ? radioRxReady : dlReady) && n < 100);
    `CHK(n < 100, 1'b1)
    {rspValid, radioRxValid, dlValid} <= 3'h0;
    {rspData, radioRxData, dlData, dlPort} <= {~b, ~b, ~b, ~port};
  endtask

  task automatic pulseDone;
    @(posedge clk_sys) cmdDone <= 1'b1;
    @(posedge clk_sys) cmdDone <= 1'b0;
  endtask

  task automatic cfg(input scr_op_t op, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (!cfgReady && n < 300);
    cfgReqValid <= 1'b1;
    cfgReq <= '{op: op, idx: idx, wdata: wd};
    @(posedge clk_sys);
    cfgReqValid <= 1'b0;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (!(cfgRdValid || cfgDone) && n < 300);
    `CHK(n < 300, 1'b1)
    rd = cfgRdData;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // thirty-three one-byte messages against a stalled radio
  task automatic tMsgLimit;
    radioQ.delete();
    @(posedge clk_sys) radioTxReady <= 1'b0;
    for (int i = 0; i < 33; i++) host_u.sendByte(8'(8'h40 + i), 30);
    `CHK(radioQ.size(), 32'd0)
    @(posedge clk_sys) radioTxReady <= 1'b1;
    `WAIT(radioQ.size() == 32, 200)
    repeat (20) @(posedge clk_sys);
    `CHK(radioQ.size(), 32'd32)
    `CHK(radioQ[31], {1'b1, 8'h5F})
  endtask

  task automatic tSeparatePlus;
    radioQ.delete();
    host_u.sendByte(8'h41, 30);
    for (int i = 0; i < 3; i++) host_u.sendByte(CH_PLUS, 30);
    `WAIT(cmdMode, 60)
    `WAIT(radioQ.size() == 3, 60)
    repeat (30) @(posedge clk_sys);
    `CHK({radioQ[0], radioQ[1], radioQ[2]}, {1'b1, 8'h41, 1'b1, CH_PLUS, 1'b1, CH_PLUS})
    `CHK(radioQ.size(), 32'd3)
  endtask

  task automatic tCommand;
    logic [23:0] e;
    e = "AT1";
    radioQ.delete();
    host_u.sendCmd("AT1");
    `WAIT(cmdValid, 20)
    `CHK(cmdLen, 8'h03)
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys) cmdRdAddr <= 7'(i);
      @(posedge clk_sys);
      #1 `CHK(cmdRdData, e[23 - 8 * i -: 8])
    end
    host_u.sendCmd("ATZ9");
    repeat (5) @(posedge clk_sys);
    `CHK(cmdLen, 8'h03)
    pulseDone();
    `WAIT(!cmdValid, 5)
    host_u.sendCmd(EXIT_TXT);
    `WAIT(!cmdMode, 20)
    `CHK({cmdValid, 32'(radioQ.size())}, 33'h0)
  endtask

  task automatic tFramePlus;
    radioQ.delete();
    host_u.sendByte(CH_PLUS, 30);
    host_u.sendByte(CH_PLUS, 0);
    host_u.sendByte(CH_PLUS, 0);
    `WAIT(cmdMode, 60)
    repeat (30) @(posedge clk_sys);
    `CHK(radioQ.size(), 32'd0)
    host_u.sendCmd(EXIT_TXT);
    `WAIT(!cmdMode, 20)
  endtask

  task automatic tDownlink;
    push(2, 8'h11, 8'h58);
    push(2, CMD_PORT, 8'h58);
    push(2, CMD_PORT, 8'h59);
    push(2, CMD_PORT, CH_LF);
    `WAIT(cmdValid, 20)
    `CHK(cmdLen, 8'h02)
    pulseDone();
    `WAIT(!cmdValid, 5)
  endtask

  // responses fill until refused with the host stalled, then radio bytes queue behind
  task automatic tSerialTx;
    int n;
    n = 0;
    host_u.setReady(1'b0);
    while (n < 600) begin
      #1;
      if (!rspReady) break;
      push(0, 8'h00, 8'(n));
      n++;
    end
    `CHK(n, SKID_DEPTH + TX_DEPTH + RSP_DEPTH)
    for (int i = 0; i < 3; i++) push(1, 8'h00, 8'(8'hB0 + i));
    `CHK(host_u.txQ.size(), 32'd0)
    host_u.setReady(1'b1);
    `WAIT(host_u.txQ.size() == n + 3, 2000)
    for (int i = 0; i < n + 3; i++) begin
      `CHK(host_u.txQ[i], (i < n) ? 8'(i) : 8'(8'hB0 + i - n))
    end
  endtask

  task automatic tConfig;
    cfg(OP_DEV_WR, 8'h05, 8'h5A);
    cfg(OP_DEV_RD, 8'h05, 8'h00);
    `CHK(rd, 8'h5A)
    cfg(OP_RST_DEV, 8'h00, 8'h00);
    cfg(OP_DEV_RD, 8'h05, 8'h00);
    `CHK(rd, 8'h00)
    cfg(OP_DEV_WR, 8'h05, 8'h5A);
    cfg(OP_SAVE_DEV, 8'h00, 8'h00);
    cfg(OP_DEV_WR, 8'h05, 8'h11);
    cfg(OP_RST_DEV, 8'h00, 8'h00);
    cfg(OP_DEV_RD, 8'h05, 8'h00);
    `CHK(rd, 8'h5A)
    cfg(OP_USR_RD, 8'h4A, 8'h00);
    idv = rd;
    cfg(OP_USR_WR, 8'h4A, ~idv);
    cfg(OP_USR_RD, 8'h4A, 8'h00);
    `CHK(rd, idv)
    for (int j = 0; j < 2; j++) begin
      cfg(OP_USR_WR, j ? 8'h60 : 8'h4B, j ? 8'hC6 : 8'hC3);
      cfg(OP_USR_RD, j ? 8'h60 : 8'h4B, 8'h00);
      `CHK(rd, j ? 8'hC6 : 8'hC3)
    end
    cfg(OP_USR_WR, 8'h61, 8'h77);
    cfg(OP_USR_RD, 8'h61, 8'h00);
    `CHK(rd, 8'h00)
    cfg(OP_SAVE_USR, 8'h00, 8'h00);
    cfg(OP_USR_WR, 8'h4B, 8'h01);
    cfg(OP_RST_USR, 8'h00, 8'h00);
    cfg(OP_USR_RD, 8'h4B, 8'h00);
    `CHK(rd, 8'hC3)
    doReset();
    cfg(OP_DEV_RD, 8'h05, 8'h00);
    `CHK(rd, 8'h5A)
    cfg(OP_USR_RD, 8'h4A, 8'h00);
    idv = rd;
    cfg(OP_FACTORY, 8'h00, 8'h00);
    cfg(OP_DEV_RD, 8'h05, 8'h00);
    `CHK(rd, 8'h5A)
    cfg(OP_RST_DEV, 8'h00, 8'h00);
    cfg(OP_RST_USR, 8'h00, 8'h00);
    cfg(OP_DEV_RD, 8'h05, 8'h00);
    `CHK(rd, FACTORY_DEV)
    cfg(OP_USR_RD, 8'h4B, 8'h00);
    `CHK(rd, FACTORY_USR)
    cfg(OP_USR_RD, 8'h4A, 8'h00);
    `CHK(rd, idv)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    doReset();
    tMsgLimit();
    tSeparatePlus();
    tCommand();
    tFramePlus();
    tDownlink();
    tSerialTx();
    tConfig();
    endOfTest();
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk_sys);
    errCount++;
    endOfTest();
  end
endmodule
